// [inc/rsc_defs.vh]
// Constants for the reset strap capture block
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// Strap bus and register widths
`define RSC_STRAP_W          25
`define RSC_DATA_W           32
`define RSC_FUNC_W           3

// Strap vector reset value: every pin idles high through its pull-up
`define RSC_STRAP_RESET      25'h1FF_FFFF

// Strap bit positions on the peripheral address bus
`define RSC_BIT_BOOT_WIDTH   0
`define RSC_BIT_CFG_RETRY    1
`define RSC_BIT_CORE0_HOLD   2
`define RSC_BIT_CORE1_HOLD   3
`define RSC_BIT_MEM_LO       4
`define RSC_BIT_MEM_HI       5
`define RSC_BIT_ARBITER      6
`define RSC_BIT_DFS_LO       7
`define RSC_BIT_DFS_HI       9
`define RSC_BIT_FUNC_OWNER   10
`define RSC_BIT_HOST_ROLE    11

// Memory speed field encodings
`define RSC_MEM_533          2'h2
`define RSC_MEM_400          2'h3

// Function numbers handed to the two translation units
`define RSC_FUNC_PRIMARY     3'h0
`define RSC_FUNC_SECONDARY   3'h5

// Device function select value for eight-port mode
`define RSC_DFS_EIGHT_PORT   3'h0

// Register byte offsets
`define RSC_OFF_STRAP_RAW    12'h000
`define RSC_OFF_STATUS       12'h004
`define RSC_OFF_CTRL         12'h008
`define RSC_OFF_CONFIG       12'h00C

// Register reset values
`define RSC_CTRL_RESET       2'h0
`define RSC_RDATA_RESET      32'h0000_0000

// Control register bit positions
`define RSC_CTRL_CORE1_REL   0
`define RSC_CTRL_CORE0_REL   1

`endif

// [src/rsc_strap_latch.v]
// Capture register that holds the sampled strap vector
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_strap_latch #(
    parameter W         = `RSC_STRAP_W,
    parameter RESET_VAL = `RSC_STRAP_RESET
) (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    input  wire         clk_en,
    // Capture control and data
    input  wire         load,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] value_ff;

    // Reset lands on the pull-up defaults; loads only on the capture strobe
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_ff <= RESET_VAL[W-1:0];
        else if (clk_en && load)
            value_ff <= d;
    end

    assign q = value_ff;

endmodule // rsc_strap_latch

`default_nettype wire

// [src/rsc_cfg_decode.v]
// Registered decode of the captured strap vector into configuration levels
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_cfg_decode (
    // Clock and reset
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     clk_en,
    // Captured straps
    input  wire [`RSC_STRAP_W-1:0]  straps,
    // Decoded configuration
    output reg                      boot_bus_16bit,
    output reg                      cfg_retry_en,
    output reg                      core0_keep_in_reset_n,
    output reg                      core1_keep_in_reset_n,
    output reg  [1:0]               memory_speed_sel,
    output reg                      memory_speed_533,
    output reg                      memory_speed_bad,
    output reg                      offchip_arbiter_sel_n,
    output reg                      function0_owner_sel_n,
    output reg  [`RSC_FUNC_W-1:0]   xbus_translation_unit_func,
    output reg  [`RSC_FUNC_W-1:0]   serial_link_translation_unit_func,
    output reg                      host_bus_endpoint_n,
    output reg  [2:0]               device_function_select,
    output reg                      eight_port_mode
);

    wire [1:0] mem_sel;
    wire       owner_n;

    assign mem_sel = {straps[`RSC_BIT_MEM_HI], straps[`RSC_BIT_MEM_LO]};
    assign owner_n = straps[`RSC_BIT_FUNC_OWNER];

    // Reset values equal the all-ones strap decode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_bus_16bit                    <= 1'b1;
            cfg_retry_en                      <= 1'b1;
            core0_keep_in_reset_n             <= 1'b1;
            core1_keep_in_reset_n             <= 1'b1;
            memory_speed_sel                  <= `RSC_MEM_400;
            memory_speed_533                  <= 1'b0;
            memory_speed_bad                  <= 1'b0;
            offchip_arbiter_sel_n             <= 1'b1;
            function0_owner_sel_n             <= 1'b1;
            xbus_translation_unit_func        <= `RSC_FUNC_SECONDARY;
            serial_link_translation_unit_func <= `RSC_FUNC_PRIMARY;
            host_bus_endpoint_n               <= 1'b1;
            device_function_select            <= 3'h7;
            eight_port_mode                   <= 1'b0;
        end
        else if (clk_en)
        begin
            boot_bus_16bit        <= straps[`RSC_BIT_BOOT_WIDTH];
            cfg_retry_en          <= straps[`RSC_BIT_CFG_RETRY];
            core0_keep_in_reset_n <= straps[`RSC_BIT_CORE0_HOLD];
            core1_keep_in_reset_n <= straps[`RSC_BIT_CORE1_HOLD];
            memory_speed_sel      <= mem_sel;
            memory_speed_533      <= (mem_sel == `RSC_MEM_533);
            // Codes 00 and 01 have no defined speed
            memory_speed_bad      <= (mem_sel != `RSC_MEM_533) && (mem_sel != `RSC_MEM_400);
            offchip_arbiter_sel_n <= straps[`RSC_BIT_ARBITER];
            function0_owner_sel_n <= owner_n;
            xbus_translation_unit_func <= owner_n ? `RSC_FUNC_SECONDARY
                                                  : `RSC_FUNC_PRIMARY;
            serial_link_translation_unit_func <= owner_n ? `RSC_FUNC_PRIMARY
                                                         : `RSC_FUNC_SECONDARY;
            host_bus_endpoint_n   <= straps[`RSC_BIT_HOST_ROLE];
            device_function_select <= straps[`RSC_BIT_DFS_HI:`RSC_BIT_DFS_LO];
            eight_port_mode <= (straps[`RSC_BIT_DFS_HI:`RSC_BIT_DFS_LO]
                                == `RSC_DFS_EIGHT_PORT);
        end
    end

endmodule // rsc_cfg_decode

`default_nettype wire

// [src/rsc_top.v]
// Reset strap capture: samples shared address pins at reset release, APB view
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_top #(
    parameter ADDR_W = 12
) (
    // Clock, reset and clock enable
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     clk_en,
    // APB slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [ADDR_W-1:0]        paddr,
    input  wire [`RSC_DATA_W-1:0]   pwdata,
    output wire [`RSC_DATA_W-1:0]   prdata,
    output wire                     pready,
    output wire                     pslverr,
    // Peripheral address bus pins, shared with the straps
    input  wire [`RSC_STRAP_W-1:0]  periph_addr_in,
    output wire [`RSC_STRAP_W-1:0]  periph_addr_out,
    output wire                     periph_addr_oe,
    // Normal-operation address from the peripheral bus controller
    input  wire [`RSC_STRAP_W-1:0]  user_addr,
    input  wire                     user_addr_en,
    // Configuration outputs
    output wire                     strap_valid,
    output wire                     boot_bus_16bit,
    output wire                     cfg_retry_en,
    output wire                     core0_hold_reset,
    output wire                     core1_hold_reset,
    output wire [1:0]               memory_speed_sel,
    output wire                     memory_speed_533,
    output wire                     memory_speed_bad,
    output wire                     offchip_arbiter_sel_n,
    output wire                     function0_owner_sel_n,
    output wire [`RSC_FUNC_W-1:0]   xbus_translation_unit_func,
    output wire [`RSC_FUNC_W-1:0]   serial_link_translation_unit_func,
    output wire                     host_bus_endpoint_n,
    output wire [2:0]               device_function_select,
    output wire                     eight_port_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Capture sequencing

    localparam ST_WAIT = 2'h0;
    localparam ST_LOAD = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg  [1:0]              state_ff;
    reg  [1:0]              nxt_state;
    reg                     valid_ff;
    wire                    load_straps;
    wire [`RSC_STRAP_W-1:0] straps;

    wire                    core0_keep_in_reset_n;
    wire                    core1_keep_in_reset_n;

    // State ladder: load once after release, then hold until the next reset
    always @*
    begin
        case (state_ff)
            ST_WAIT: nxt_state = ST_LOAD;
            ST_LOAD: nxt_state = ST_HOLD;
            ST_HOLD: nxt_state = ST_HOLD;
            default: nxt_state = ST_WAIT;
        endcase
    end

    // Async reset parks the ladder; the pins are read only by the clocked load
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= ST_WAIT;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // Sample on the first enabled edge after release, never again
    assign load_straps = (state_ff == ST_WAIT);

    // Decoded outputs lag the capture by one edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            valid_ff <= 1'b0;
        else if (clk_en && state_ff == ST_LOAD)
            valid_ff <= 1'b1;
    end

    assign strap_valid = valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sharing

    // Pins stay undriven until capture is over so the pulls set the level;
    // an early drive would overwrite every strap with bus traffic
    assign periph_addr_oe  = (state_ff == ST_HOLD) && user_addr_en;
    assign periph_addr_out = user_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap storage and decode

    rsc_strap_latch #(
        .W         (`RSC_STRAP_W),
        .RESET_VAL (`RSC_STRAP_RESET)
    ) u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .load    (load_straps),
        .d       (periph_addr_in),
        .q       (straps)
    );

    rsc_cfg_decode u_decode (
        .pclk                              (pclk),
        .presetn                           (presetn),
        .clk_en                            (clk_en),
        .straps                            (straps),
        .boot_bus_16bit                    (boot_bus_16bit),
        .cfg_retry_en                      (cfg_retry_en),
        .core0_keep_in_reset_n             (core0_keep_in_reset_n),
        .core1_keep_in_reset_n             (core1_keep_in_reset_n),
        .memory_speed_sel                  (memory_speed_sel),
        .memory_speed_533                  (memory_speed_533),
        .memory_speed_bad                  (memory_speed_bad),
        .offchip_arbiter_sel_n             (offchip_arbiter_sel_n),
        .function0_owner_sel_n             (function0_owner_sel_n),
        .xbus_translation_unit_func        (xbus_translation_unit_func),
        .serial_link_translation_unit_func (serial_link_translation_unit_func),
        .host_bus_endpoint_n               (host_bus_endpoint_n),
        .device_function_select            (device_function_select),
        .eight_port_mode                   (eight_port_mode)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Core hold logic

    reg  [1:0] ctrl_ff;
    reg  [1:0] nxt_ctrl;
    reg        hold0_ff;
    reg        hold1_ff;

    // A core is held while its strap reads zero and software has not released it;
    // core 0 normally runs the code that would write the release, so its release
    // bit only helps when another master reaches the bus
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold0_ff <= 1'b1;
            hold1_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            hold0_ff <= !valid_ff || (!core0_keep_in_reset_n
                        && !ctrl_ff[`RSC_CTRL_CORE0_REL]);
            hold1_ff <= !valid_ff || (!core1_keep_in_reset_n
                        && !ctrl_ff[`RSC_CTRL_CORE1_REL]);
        end
    end

    assign core0_hold_reset = hold0_ff;
    assign core1_hold_reset = hold1_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire setup_ph;
    wire access_ph;
    wire hit_raw;
    wire hit_status;
    wire hit_ctrl;
    wire hit_config;
    wire hit_any;

    assign setup_ph   = psel && !penable;
    assign access_ph  = psel && penable;
    assign hit_raw    = (paddr == `RSC_OFF_STRAP_RAW);
    assign hit_status = (paddr == `RSC_OFF_STATUS);
    assign hit_ctrl   = (paddr == `RSC_OFF_CTRL);
    assign hit_config = (paddr == `RSC_OFF_CONFIG);
    assign hit_any    = hit_raw || hit_status || hit_ctrl || hit_config;

    // Zero wait states; unmapped addresses and writes to read-only words error
    assign pready  = 1'b1;
    assign pslverr = access_ph && (!hit_any || (pwrite && !hit_ctrl));

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    // Only the control word is writable; the strap image can never be altered
    always @*
    begin
        nxt_ctrl = ctrl_ff;
        if (access_ph && pwrite && hit_ctrl)
            nxt_ctrl = pwdata[1:0];
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= `RSC_CTRL_RESET;
        else if (clk_en)
            ctrl_ff <= nxt_ctrl;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    reg  [`RSC_DATA_W-1:0] rdata_ff;
    reg  [`RSC_DATA_W-1:0] nxt_rdata;
    wire [`RSC_DATA_W-1:0] status_word;
    wire [`RSC_DATA_W-1:0] config_word;

    // Status: progress of the capture and the live hold levels
    assign status_word = {26'h000_0000, hold1_ff, hold0_ff, eight_port_mode,
                          memory_speed_bad, valid_ff, (state_ff == ST_HOLD)};

    // Config: decoded view of the straps
    assign config_word = {14'h0000, serial_link_translation_unit_func,
                          xbus_translation_unit_func, device_function_select,
                          host_bus_endpoint_n, function0_owner_sel_n,
                          offchip_arbiter_sel_n, memory_speed_sel,
                          core1_keep_in_reset_n, core0_keep_in_reset_n,
                          cfg_retry_en, boot_bus_16bit};

    // Read word is picked in the setup cycle so it sits in a flop at access
    always @*
    begin
        nxt_rdata = rdata_ff;
        if (setup_ph && !pwrite)
        begin
            if (hit_raw)
                nxt_rdata = {7'h00, straps};
            else if (hit_status)
                nxt_rdata = status_word;
            else if (hit_ctrl)
                nxt_rdata = {30'h0000_0000, ctrl_ff};
            else if (hit_config)
                nxt_rdata = config_word;
            else
                nxt_rdata = `RSC_RDATA_RESET;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_ff <= `RSC_RDATA_RESET;
        else if (clk_en)
            rdata_ff <= nxt_rdata;
    end

    assign prdata = rdata_ff;

endmodule // rsc_top

`default_nettype wire

// [verification/rsc_strap_board.sv]
// Board model: strap resistors and pin resolution on the shared address bus
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_strap_board (
    // Pull-down resistors fitted on the board, one bit per pin
    input  wire logic [`RSC_STRAP_W-1:0] pulldown_fit,
    // Device drive of the shared pins
    input  wire logic [`RSC_STRAP_W-1:0] drive_val,
    input  wire logic                    drive_en,
    // Resolved pin level seen by the device
    output logic      [`RSC_STRAP_W-1:0] pin_level
);
    // Undriven pins float to the pull-up unless a pull-down is fitted
    assign pin_level = drive_en ? drive_val : ~pulldown_fit;
endmodule // rsc_strap_board

`default_nettype wire

// [verification/rsc_top_props.sv]
// Concurrent checks on the captured strap configuration
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_top_props (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Shared pins
    input wire logic [`RSC_STRAP_W-1:0] periph_addr_in,
    input wire logic                    periph_addr_oe,
    // Decoded configuration
    input wire logic                    strap_valid,
    input wire logic                    boot_bus_16bit,
    input wire logic                    cfg_retry_en,
    input wire logic                    core0_hold_reset,
    input wire logic                    core1_hold_reset,
    input wire logic [1:0]              memory_speed_sel,
    input wire logic                    memory_speed_533,
    input wire logic                    offchip_arbiter_sel_n,
    input wire logic                    function0_owner_sel_n,
    input wire logic [`RSC_FUNC_W-1:0]  xbus_translation_unit_func,
    input wire logic [`RSC_FUNC_W-1:0]  serial_link_translation_unit_func,
    input wire logic                    host_bus_endpoint_n,
    input wire logic [2:0]              device_function_select
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Image is taken one edge before valid rises, so pins sit two ticks back
    sequence capture_s;
        !strap_valid ##1 strap_valid;
    endsequence

    boot_width_a: assert property (capture_s |-> boot_bus_16bit == $past(periph_addr_in[0], 2))
        else $error("boot width not from strap");
    cfg_retry_a: assert property (capture_s |-> cfg_retry_en == $past(periph_addr_in[1], 2))
        else $error("retry not from strap");
    core_hold_a: assert property (capture_s |=> core0_hold_reset == !$past(periph_addr_in[2], 3)
        && core1_hold_reset == !$past(periph_addr_in[3], 3)) else $error("core hold wrong");
    mem_field_a: assert property (capture_s |-> memory_speed_sel == $past(periph_addr_in[5:4], 2))
        else $error("memory field wrong");
    mem_speed_a: assert property (strap_valid |-> memory_speed_533 == (memory_speed_sel == 2'h2))
        else $error("memory speed decode wrong");
    arbiter_sel_a: assert property (capture_s |-> offchip_arbiter_sel_n == $past(periph_addr_in[6], 2))
        else $error("arbiter select wrong");
    func_owner_a: assert property (strap_valid |->
        ({xbus_translation_unit_func, serial_link_translation_unit_func} == (function0_owner_sel_n ?
        {`RSC_FUNC_SECONDARY, `RSC_FUNC_PRIMARY} : {`RSC_FUNC_PRIMARY, `RSC_FUNC_SECONDARY})))
        else $error("function numbers wrong");
    host_role_a: assert property (capture_s |-> host_bus_endpoint_n == $past(periph_addr_in[11], 2))
        else $error("host role wrong");
    func_select_a: assert property (capture_s |-> device_function_select == $past(periph_addr_in[9:7], 2))
        else $error("function select wrong");
    straps_frozen_a: assert property (strap_valid [*2] |-> $stable({boot_bus_16bit, cfg_retry_en,
        memory_speed_sel, offchip_arbiter_sel_n, function0_owner_sel_n, host_bus_endpoint_n,
        device_function_select})) else $error("captured straps moved");
    pin_drive_a: assert property (periph_addr_oe |-> strap_valid)
        else $error("pins driven before capture");
endmodule // rsc_top_props

bind rsc_top rsc_top_props u_props (.pclk(pclk), .presetn(presetn), .periph_addr_in(periph_addr_in),
    .periph_addr_oe(periph_addr_oe), .strap_valid(strap_valid), .boot_bus_16bit(boot_bus_16bit),
    .cfg_retry_en(cfg_retry_en), .core0_hold_reset(core0_hold_reset),
    .core1_hold_reset(core1_hold_reset), .memory_speed_sel(memory_speed_sel),
    .memory_speed_533(memory_speed_533), .offchip_arbiter_sel_n(offchip_arbiter_sel_n),
    .function0_owner_sel_n(function0_owner_sel_n),
    .xbus_translation_unit_func(xbus_translation_unit_func),
    .serial_link_translation_unit_func(serial_link_translation_unit_func),
    .host_bus_endpoint_n(host_bus_endpoint_n), .device_function_select(device_function_select));

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the reset strap capture block
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.vh"

module tb;
    // Row: pull-downs fitted, expected straps in pin order
    typedef struct packed
    {
        logic [24:0] mask;
        logic [11:0] exp;
    } rsc_row_t;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, user_addr_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [24:0] pulldown_fit, user_addr;
    logic [11:0] e;
    logic        er;
    int          miscompares, num_checks;
    wire logic [31:0] prdata;
    wire logic [24:0] pins, addr_out;
    wire logic [2:0]  xfunc, sfunc, dfs;
    wire logic [1:0]  msel;
    wire logic        pready, pslverr, oe, valid, boot16, retry, hold0, hold1, m533, mbad;
    wire logic        arb_n, owner_n, ep_n, eight;
    rsc_row_t rows [0:10] = '{'{25'h000_0000, 12'hFFF}, '{25'h000_0001, 12'hFFE},
        '{25'h000_0002, 12'hFFD}, '{25'h000_0004, 12'hFFB}, '{25'h000_0008, 12'hFF7},
        '{25'h000_0010, 12'hFEF}, '{25'h000_0040, 12'hFBF}, '{25'h000_0380, 12'hC7F},
        '{25'h000_0400, 12'hBFF}, '{25'h000_0800, 12'h7FF}, '{25'h1FF_FFFF, 12'h000}};

    ////////////////////////////////////////////////////////////////////////////////
    // Design, board and clock
    rsc_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_addr_in(pins), .periph_addr_out(addr_out),
        .periph_addr_oe(oe), .user_addr(user_addr), .user_addr_en(user_addr_en),
        .strap_valid(valid), .boot_bus_16bit(boot16), .cfg_retry_en(retry),
        .core0_hold_reset(hold0), .core1_hold_reset(hold1), .memory_speed_sel(msel),
        .memory_speed_533(m533), .memory_speed_bad(mbad), .offchip_arbiter_sel_n(arb_n),
        .function0_owner_sel_n(owner_n), .xbus_translation_unit_func(xfunc),
        .serial_link_translation_unit_func(sfunc), .host_bus_endpoint_n(ep_n),
        .device_function_select(dfs), .eight_port_mode(eight));
    rsc_strap_board u_board (.pulldown_fit(pulldown_fit), .drive_val(addr_out), .drive_en(oe),
        .pin_level(pins));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            num_checks++;
            if (got !== exp)
            begin
                miscompares++;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("Checks %0d, mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Long reset with the board fit applied, then wait for the capture
    task do_reset(input logic [24:0] mask);
        int n;
        begin
            presetn      <= 1'b0;
            pulldown_fit <= mask;
            repeat (12) @(posedge pclk);
            presetn <= 1'b1;
            n = 0;
            while (valid !== 1'b1 && n < 20)
            begin
                @(posedge pclk);
                n++;
            end
            // Core holds settle one edge after valid
            repeat (2) @(posedge pclk);
            chk(valid, 1'b1);
        end
    endtask

    // One APB transfer; an idle edge first so psel is never reassigned in a step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        begin
            @(posedge pclk);
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50)
            begin
                @(posedge pclk);
                n++;
            end
            rd = prdata;
            er = pslverr;
            chk(n < 50, 1'b1);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; user_addr = 25'h000_0000; user_addr_en = 1'b0;
        pulldown_fit = 25'h000_0000; miscompares = 0; num_checks = 0;
        for (int i = 0; i < 11; i++)
        begin
            e = rows[i].exp;
            do_reset(rows[i].mask);
            chk(boot16, e[0]);
            chk(retry, e[1]);
            chk(hold0, !e[2]);
            chk(hold1, !e[3]);
            chk(msel, e[5:4]);
            chk(m533, e[5:4] == 2'h2);
            chk(mbad, !e[5]);
            chk(arb_n, e[6]);
            chk(owner_n, e[10]);
            chk(xfunc, e[10] ? `RSC_FUNC_SECONDARY : `RSC_FUNC_PRIMARY);
            chk(sfunc, e[10] ? `RSC_FUNC_PRIMARY : `RSC_FUNC_SECONDARY);
            chk(ep_n, e[11]);
            chk(dfs, e[9:7]);
            chk(eight, e[9:7] == `RSC_DFS_EIGHT_PORT);
            $display("Strap row %0d done", i);
        end
        // Mid-run pin traffic must not disturb the capture
        do_reset(25'h155_000C);
        apb(1'b0, `RSC_OFF_STRAP_RAW, 32'h0000_0000);
        chk(rd, 32'h00AA_FFF3);
        user_addr    <= 25'h0F0_F0F0;
        user_addr_en <= 1'b1;
        pulldown_fit <= 25'h0AA_FFF3;
        repeat (6) @(posedge pclk);
        chk(pins, 25'h0F0_F0F0);
        user_addr_en <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({boot16, retry, msel, dfs, owner_n, ep_n, hold0, hold1}, 32'h0000_07FF);
        apb(1'b0, `RSC_OFF_STRAP_RAW, 32'h0000_0000);
        chk(rd, 32'h00AA_FFF3);
        $display("Capture freeze done");
        // Core release through control, then refused accesses
        apb(1'b1, `RSC_OFF_CTRL, 32'h0000_0003);
        chk(er, 1'b0);
        repeat (2) @(posedge pclk);
        chk({hold0, hold1}, 2'b00);
        apb(1'b0, `RSC_OFF_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'b1, `RSC_OFF_CONFIG, 32'hFFFF_FFFF);
        chk(er, 1'b1);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({er, rd}, {1'b1, 32'h0000_0000});
        $display("Register access done");
        // Capture waits for the clock enable after release
        clk_en  <= 1'b0;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(valid, 1'b0);
        clk_en <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(valid, 1'b1);
        $display("Clock enable hold done");
        test_done;
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end
endmodule // tb

`default_nettype wire
